/* ofr_pkg.sv */
// Constants, types and helpers for the output fault response block.
// Assumes a single 25 MHz core clock; all times derive from it here.
package ofr_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned OVUV_UNIT_NS   = 10000;
  localparam int unsigned OVUV_UNIT_CYC  = OVUV_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_NS          = 1000000;
  localparam int unsigned MS_CYC_DEF     = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned OC_UNIT_MS     = 16;
  localparam int unsigned RAMP_NS        = 100000;
  localparam int unsigned RAMP_CYC_DEF   = RAMP_NS / CLK_PERIOD_NS;

  // Command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_RESTORE_ALL  = 8'h16;
  localparam logic [7:0] CMD_OV_RESP      = 8'h41;
  localparam logic [7:0] CMD_UV_RESP      = 8'h45;
  localparam logic [7:0] CMD_OC_RESP      = 8'h47;
  localparam logic [7:0] CMD_STATUS_BYTE  = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
  localparam logic [7:0] CMD_STATUS_VOUT  = 8'h7A;
  localparam logic [7:0] CMD_STATUS_IOUT  = 8'h7B;
  localparam logic [7:0] CMD_RETRY_INTVL  = 8'hDB;
  localparam logic [7:0] CMD_SOFT_RESET   = 8'hFD;

  // Reset values
  localparam logic [7:0]  OV_CFG_RST    = 8'h80;
  localparam logic [7:0]  UV_CFG_RST    = 8'hB8;
  localparam logic [7:0]  OC_CFG_RST    = 8'h00;
  localparam logic [15:0] RETRY_RST     = 16'hFABC;

  // Response byte fields
  localparam int ACT_HI = 7;
  localparam int ACT_LO = 6;
  localparam int RTY_HI = 5;
  localparam int RTY_LO = 3;
  localparam int DLY_HI = 2;
  localparam int DLY_LO = 0;
  localparam logic [1:0] ACT_IGNORE   = 2'b00;
  localparam logic [1:0] ACT_V_DELAY  = 2'b01;
  localparam logic [1:0] ACT_V_NOW    = 2'b10;
  localparam logic [1:0] ACT_V_BAD    = 2'b11;
  localparam logic [1:0] ACT_OC_BAD   = 2'b01;
  localparam logic [1:0] ACT_OC_DELAY = 2'b10;
  localparam logic [1:0] ACT_OC_NOW   = 2'b11;
  localparam logic [2:0] RTY_FOREVER  = 3'b111;

  // Status bit positions
  localparam int SB_VOUT_OV = 5;
  localparam int SB_IOUT_OC = 4;
  localparam int SB_CML     = 1;
  localparam int SW_VOUT    = 15;
  localparam int SW_IOUT    = 14;
  localparam int SV_OV      = 7;
  localparam int SV_UV      = 4;
  localparam int SI_OC      = 7;

  // Flag vector / alert mask positions
  localparam int FL_OV  = 0;
  localparam int FL_UV  = 1;
  localparam int FL_OC  = 2;
  localparam int FL_CML = 3;
  localparam int FL_N   = 4;

  // Synchronised pin positions
  localparam int PIN_OV   = 0;
  localparam int PIN_PS   = 1;
  localparam int PIN_UVLO = 2;
  localparam int PIN_GDS  = 3;
  localparam int PIN_UV   = 4;
  localparam int PIN_OC   = 5;
  localparam int PIN_RUN  = 6;
  localparam int PIN_N    = 7;

  typedef enum logic [1:0] {
    RSP_IGNORE = 2'b00,
    RSP_DELAY  = 2'b01,
    RSP_NOW    = 2'b10
  } ofr_rsp_t;

  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_RAMP_ON  = 3'b001,
    ST_ON       = 3'b010,
    ST_RAMP_OFF = 3'b011,
    ST_LATCH    = 3'b100,
    ST_RETRY    = 3'b101
  } ofr_state_t;

  function automatic ofr_rsp_t dec_vout(input logic [1:0] act);
    case (act)
      ACT_V_DELAY: dec_vout = RSP_DELAY;
      ACT_V_NOW:   dec_vout = RSP_NOW;
      default:     dec_vout = RSP_IGNORE;
    endcase
  endfunction

  function automatic ofr_rsp_t dec_iout(input logic [1:0] act);
    case (act)
      ACT_OC_DELAY: dec_iout = RSP_DELAY;
      ACT_OC_NOW:   dec_iout = RSP_NOW;
      default:      dec_iout = RSP_IGNORE;
    endcase
  endfunction

  // Linear 5s/11s word to whole milliseconds; negative mantissa reads 0
  function automatic logic [23:0] l11_to_ms(input logic [15:0] w);
    logic signed [4:0] e;
    logic [23:0]       m;
    e = w[15:11];
    m = w[10] ? 24'h00_0000 : {13'h0000, w[10:0]};
    if (e < 0) begin
      l11_to_ms = m >> 5'(-e);
    end else begin
      l11_to_ms = m << 5'(e);
    end
  endfunction

endpackage

/* ofr_tmr_if.sv */
// Link between the fault engine and one response delay timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ofr_tmr_if;
  import ofr_pkg::*;
  logic       fault;
  ofr_rsp_t   mode;
  logic [2:0] dly;
  logic       tick;
  logic       trip;
  modport eng (input fault, input mode, input dly, input tick,
               output trip);
  modport ctl (output fault, output mode, output dly, output tick,
               input trip);
endinterface
`default_nettype wire

/* ofr_resp_timer.sv */
// Response delay timer for one fault channel.
// Assumes fault is already synchronised and gated to operating states.
`timescale 1ns/1ps
`default_nettype none
module ofr_resp_timer
  import ofr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  ofr_tmr_if.eng    tif
);
  logic [3:0] cnt_reg;
  logic       done_reg;

  wire logic run    = tif.fault && (tif.mode == RSP_DELAY);
  // First tick is partial, so one extra tick guarantees the full delay
  wire logic expire = run && ((tif.dly == 3'h0) ||
                              (cnt_reg > {1'b0, tif.dly}));
  wire logic now    = tif.fault && (tif.mode == RSP_NOW);
  wire logic drop   = !tif.fault || (tif.mode == RSP_IGNORE);

  assign tif.trip = (expire || now) && !done_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 4'h0;
      done_reg <= 1'b0;
    end else if (ce) begin
      if (drop) begin
        cnt_reg  <= 4'h0;
        done_reg <= 1'b0;
      end else begin
        if (tif.trip) done_reg <= 1'b1;
        if (run && tif.tick && !expire) cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_drop_restarts: assert property (
    ce && !tif.fault |=> cnt_reg == 4'h0)
    else $error("delay count survived a fault dropout");
  chk_ignore_no_trip: assert property (
    tif.mode == RSP_IGNORE |-> !tif.trip)
    else $error("ignore mode tripped");
  chk_now_trips: assert property (
    ce && now && !done_reg |-> tif.trip ##1 (done_reg || !tif.fault))
    else $error("immediate mode did not trip");
  chk_delay_not_early: assert property (
    run && tif.dly != 3'h0 && cnt_reg <= {1'b0, tif.dly} |-> !tif.trip)
    else $error("delayed trip came early");

endmodule // ofr_resp_timer
`default_nettype wire

/* ofr_fault_resp.sv */
// Output fault response engine for one regulator page: status flags,
// alert, response configuration bytes and the output on/off sequencer.
// Assumes a command decoder on the same clock presents one command per
// valid pulse; fault and run pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - OV response also covers stage, UVLO, gate-supply faults
// - OV fault sets three status bits, alert
// - OV response byte readable only, writes refused
// - UV fault sets two status bits, alert
// - UV response byte readable and writable
// - Action 00: keep running, still flag status
// - Action 01: shut down after uninterrupted delay
// - Action 10: shut down at once
// - Writing action 11 flags a CML fault
// - Latched status cleared only by listed events
// - Retry 000-110: stay off until cleared
// - Retry 111: restart forever at retry interval
// - Delay in 10 us units, hardware keeps reacting
// - OC fault sets three status bits, alert
// - OC ignored while ramping on or off
// - OC delay 16 ms units, reads zero sometimes
// - Retry interval is minimum restart wait, 350 ms
module ofr_fault_resp
  import ofr_pkg::*;
#(
  parameter int unsigned MS_CYC   = MS_CYC_DEF,
  parameter int unsigned RAMP_CYC = RAMP_CYC_DEF
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        CMD_VALID,
  input  wire logic        CMD_WRITE,
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic [15:0] CMD_DATA,
  input  wire logic        OPERATION_ON,
  input  wire logic [3:0]  ALERT_MASK,
  input  wire logic        OV_FAULT_IN,
  input  wire logic        PSTAGE_FAULT_IN,
  input  wire logic        UVLO_FAULT_IN,
  input  wire logic        GDS_UV_FAULT_IN,
  input  wire logic        UV_FAULT_IN,
  input  wire logic        OC_FAULT_IN,
  input  wire logic        RUN_IN,
  output logic             RSP_VALID,
  output logic [15:0]      RSP_DATA,
  output logic             OUTPUT_EN,
  output logic             RAMPING,
  output logic             ALERT_N
);
  localparam int MSW = $clog2(MS_CYC);
  localparam logic [7:0]     US10_LAST = 8'(OVUV_UNIT_CYC - 1);
  localparam logic [MSW-1:0] MS_LAST   = MSW'(MS_CYC - 1);
  localparam logic [3:0]     OC_LAST   = 4'(OC_UNIT_MS - 1);
  localparam logic [15:0]    RAMP_LAST = 16'(RAMP_CYC - 1);

  // Pin synchronisers
  logic [PIN_N-1:0] pin_s1_reg;
  logic [PIN_N-1:0] pin_s2_reg;
  wire logic [PIN_N-1:0] pins_raw = {RUN_IN, OC_FAULT_IN, UV_FAULT_IN,
    GDS_UV_FAULT_IN, UVLO_FAULT_IN, PSTAGE_FAULT_IN, OV_FAULT_IN};

  // Registers
  logic [7:0]     ov_cfg_reg;
  logic [7:0]     uv_cfg_reg;
  logic [7:0]     oc_cfg_reg;
  logic [15:0]    retry_reg;
  logic [FL_N-1:0] flag_reg;
  logic [FL_N-1:0] flag_next;
  ofr_state_t     state_reg;
  ofr_state_t     state_next;
  logic           run_prev_reg;
  logic [7:0]     us_cnt_reg;
  logic [MSW-1:0] ms_cnt_reg;
  logic [3:0]     oc_cnt_reg;
  logic [15:0]    ramp_cnt_reg;
  logic [23:0]    rty_cnt_reg;
  logic           rsp_valid_reg;
  logic [15:0]    rsp_data_reg;
  logic           out_en_reg;
  logic           ramping_reg;
  logic           alert_n_reg;

  // Time base
  wire logic tick_us10 = (us_cnt_reg == US10_LAST);
  wire logic tick_ms   = (ms_cnt_reg == MS_LAST);
  wire logic tick_oc   = tick_ms && (oc_cnt_reg == OC_LAST);

  // Run request and off-then-on detection
  wire logic run_on  = pin_s2_reg[PIN_RUN] && OPERATION_ON;
  wire logic on_edge = run_on && !run_prev_reg;

  // Command decode
  wire logic wr = CMD_VALID && CMD_WRITE;
  wire logic rd = CMD_VALID && !CMD_WRITE;
  wire logic [1:0] wr_act = CMD_DATA[ACT_HI:ACT_LO];
  wire logic wr_ov    = wr && (CMD_CODE == CMD_OV_RESP);
  wire logic wr_uv    = wr && (CMD_CODE == CMD_UV_RESP);
  wire logic wr_oc    = wr && (CMD_CODE == CMD_OC_RESP);
  wire logic wr_rty   = wr && (CMD_CODE == CMD_RETRY_INTVL);
  wire logic wr_svout = wr && (CMD_CODE == CMD_STATUS_VOUT);
  wire logic wr_siout = wr && (CMD_CODE == CMD_STATUS_IOUT);
  wire logic clr_cmd  = wr && ((CMD_CODE == CMD_CLEAR_FAULTS) ||
                               (CMD_CODE == CMD_RESTORE_ALL) ||
                               (CMD_CODE == CMD_SOFT_RESET));
  wire logic uv_bad   = wr_uv && (wr_act == ACT_V_BAD);
  wire logic oc_bad   = wr_oc && (wr_act == ACT_OC_BAD);
  wire logic known    = (CMD_CODE == CMD_OV_RESP) ||
    (CMD_CODE == CMD_UV_RESP) || (CMD_CODE == CMD_OC_RESP) ||
    (CMD_CODE == CMD_RETRY_INTVL) || (CMD_CODE == CMD_STATUS_BYTE) ||
    (CMD_CODE == CMD_STATUS_WORD) || (CMD_CODE == CMD_STATUS_VOUT) ||
    (CMD_CODE == CMD_STATUS_IOUT) || (CMD_CODE == CMD_CLEAR_FAULTS) ||
    (CMD_CODE == CMD_RESTORE_ALL) || (CMD_CODE == CMD_SOFT_RESET);
  // Read-only byte, bad action codes and unknown codes raise CML
  wire logic cml_set  = wr_ov || uv_bad || oc_bad ||
                        (CMD_VALID && !known);

  // Operating state gating
  wire logic powered  = (state_reg == ST_RAMP_ON) ||
                        (state_reg == ST_ON) ||
                        (state_reg == ST_RAMP_OFF);
  wire logic ov_evt   = powered && (pin_s2_reg[PIN_OV] ||
    pin_s2_reg[PIN_PS] || pin_s2_reg[PIN_UVLO] ||
    pin_s2_reg[PIN_GDS]);
  wire logic uv_evt   = powered && pin_s2_reg[PIN_UV];
  wire logic oc_evt   = (state_reg == ST_ON) &&
                        pin_s2_reg[PIN_OC];

  // Delay timers
  ofr_tmr_if ov_tif ();
  ofr_tmr_if uv_tif ();
  ofr_tmr_if oc_tif ();
  assign ov_tif.fault = ov_evt;
  assign ov_tif.mode  = dec_vout(ov_cfg_reg[ACT_HI:ACT_LO]);
  assign ov_tif.dly   = ov_cfg_reg[DLY_HI:DLY_LO];
  assign ov_tif.tick  = tick_us10;
  assign uv_tif.fault = uv_evt;
  assign uv_tif.mode  = dec_vout(uv_cfg_reg[ACT_HI:ACT_LO]);
  assign uv_tif.dly   = uv_cfg_reg[DLY_HI:DLY_LO];
  assign uv_tif.tick  = tick_us10;
  assign oc_tif.fault = oc_evt;
  assign oc_tif.mode  = dec_iout(oc_cfg_reg[ACT_HI:ACT_LO]);
  assign oc_tif.dly   = oc_cfg_reg[DLY_HI:DLY_LO];
  assign oc_tif.tick  = tick_oc;

  ofr_resp_timer u_ov_tmr (.clk(CLK), .rst(RST), .ce(CE), .tif(ov_tif));
  ofr_resp_timer u_uv_tmr (.clk(CLK), .rst(RST), .ce(CE), .tif(uv_tif));
  ofr_resp_timer u_oc_tmr (.clk(CLK), .rst(RST), .ce(CE), .tif(oc_tif));

  wire logic trip_any = ov_tif.trip || uv_tif.trip || oc_tif.trip;
  // One tripping channel without retry overrides any that would retry
  wire logic no_retry = (ov_tif.trip &&
      (ov_cfg_reg[RTY_HI:RTY_LO] != RTY_FOREVER)) ||
    (uv_tif.trip && (uv_cfg_reg[RTY_HI:RTY_LO] != RTY_FOREVER)) ||
    (oc_tif.trip && (oc_cfg_reg[RTY_HI:RTY_LO] != RTY_FOREVER));
  wire ofr_state_t shut_state = no_retry ? ST_LATCH : ST_RETRY;

  wire logic [23:0] retry_ms = l11_to_ms(retry_reg);
  wire logic retry_done = rty_cnt_reg > retry_ms;
  wire logic ramp_done  = ramp_cnt_reg == RAMP_LAST;
  wire logic clear_all  = clr_cmd || on_edge;

  // Output sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:      if (run_on) state_next = ST_RAMP_ON;
      ST_RAMP_ON: begin
        if (trip_any) state_next = shut_state;
        else if (!run_on) state_next = ST_RAMP_OFF;
        else if (ramp_done) state_next = ST_ON;
      end
      ST_ON: begin
        if (trip_any) state_next = shut_state;
        else if (!run_on) state_next = ST_RAMP_OFF;
      end
      ST_RAMP_OFF: begin
        if (trip_any) state_next = shut_state;
        else if (ramp_done) state_next = ST_OFF;
      end
      ST_LATCH:    if (!run_on || clr_cmd) state_next = ST_OFF;
      ST_RETRY: begin
        if (!run_on) state_next = ST_OFF;
        else if (retry_done) state_next = ST_RAMP_ON;
      end
      default:     state_next = ST_OFF;
    endcase
  end

  // Sticky flags: a new event wins over a clear in the same cycle
  wire logic [FL_N-1:0] flag_set = {cml_set, oc_evt, uv_evt, ov_evt};
  wire logic [FL_N-1:0] flag_clr = {clear_all,
    clear_all || (wr_siout && CMD_DATA[SI_OC]),
    clear_all || (wr_svout && CMD_DATA[SV_UV]),
    clear_all || (wr_svout && CMD_DATA[SV_OV])};
  assign flag_next = flag_set | (flag_reg & ~flag_clr);

  // Read-back views
  wire logic [7:0] stat_byte = (8'(flag_reg[FL_OV]) << SB_VOUT_OV) |
    (8'(flag_reg[FL_OC]) << SB_IOUT_OC) |
    (8'(flag_reg[FL_CML]) << SB_CML);
  wire logic [15:0] stat_word = {8'h00, stat_byte} |
    (16'(flag_reg[FL_OV] || flag_reg[FL_UV]) << SW_VOUT) |
    (16'(flag_reg[FL_OC]) << SW_IOUT);
  wire logic [7:0] stat_vout = (8'(flag_reg[FL_OV]) << SV_OV) |
    (8'(flag_reg[FL_UV]) << SV_UV);
  wire logic [7:0] stat_iout = 8'(flag_reg[FL_OC]) << SI_OC;
  wire logic oc_dly_hide = (oc_cfg_reg[ACT_HI:ACT_LO] == ACT_IGNORE) ||
                           (oc_cfg_reg[ACT_HI:ACT_LO] == ACT_OC_NOW);
  wire logic [7:0] oc_view = {oc_cfg_reg[ACT_HI:RTY_LO],
    oc_dly_hide ? 3'h0 : oc_cfg_reg[DLY_HI:DLY_LO]};
  logic [15:0] rd_mux;
  always_comb begin
    case (CMD_CODE)
      CMD_OV_RESP:     rd_mux = {8'h00, ov_cfg_reg};
      CMD_UV_RESP:     rd_mux = {8'h00, uv_cfg_reg};
      CMD_OC_RESP:     rd_mux = {8'h00, oc_view};
      CMD_RETRY_INTVL: rd_mux = retry_reg;
      CMD_STATUS_BYTE: rd_mux = {8'h00, stat_byte};
      CMD_STATUS_WORD: rd_mux = stat_word;
      CMD_STATUS_VOUT: rd_mux = {8'h00, stat_vout};
      CMD_STATUS_IOUT: rd_mux = {8'h00, stat_iout};
      default:         rd_mux = 16'h0000;
    endcase
  end

  wire logic st_change = state_next != state_reg;
  wire logic pwr_next  = (state_next == ST_RAMP_ON) ||
                         (state_next == ST_ON) ||
                         (state_next == ST_RAMP_OFF);
  wire logic ramp_next = (state_next == ST_RAMP_ON) ||
                         (state_next == ST_RAMP_OFF);
  wire logic [FL_N-1:0] flag_live = flag_next & ~ALERT_MASK;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else if (CE) begin
      pin_s1_reg <= pins_raw;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ov_cfg_reg <= OV_CFG_RST;
      uv_cfg_reg <= UV_CFG_RST;
      oc_cfg_reg <= OC_CFG_RST;
      retry_reg  <= RETRY_RST;
    end else if (CE) begin
      if (wr_uv && !uv_bad) uv_cfg_reg <= CMD_DATA[7:0];
      if (wr_oc && !oc_bad) oc_cfg_reg <= CMD_DATA[7:0];
      if (wr_rty) retry_reg <= CMD_DATA;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      us_cnt_reg <= 8'h00;
      ms_cnt_reg <= '0;
      oc_cnt_reg <= 4'h0;
    end else if (CE) begin
      us_cnt_reg <= tick_us10 ? 8'h00 : us_cnt_reg + 8'h01;
      ms_cnt_reg <= tick_ms ? '0 : ms_cnt_reg + MSW'(1);
      if (tick_ms) oc_cnt_reg <= tick_oc ? 4'h0 : oc_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg    <= ST_OFF;
      run_prev_reg <= 1'b0;
      ramp_cnt_reg <= 16'h0000;
      rty_cnt_reg  <= 24'h00_0000;
      flag_reg     <= '0;
    end else if (CE) begin
      state_reg    <= state_next;
      run_prev_reg <= run_on;
      ramp_cnt_reg <= st_change ? 16'h0000 : ramp_cnt_reg + 16'h0001;
      if (st_change) rty_cnt_reg <= 24'h00_0000;
      else if (tick_ms && !retry_done)
        rty_cnt_reg <= rty_cnt_reg + 24'h00_0001;
      flag_reg     <= flag_next;
    end
  end

  // Outputs: the output stays enabled while a delay runs, so the
  // hardware-level reaction of the power stage carries on meanwhile
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= 16'h0000;
      out_en_reg    <= 1'b0;
      ramping_reg   <= 1'b0;
      alert_n_reg   <= 1'b1;
    end else if (CE) begin
      rsp_valid_reg <= rd;
      if (rd) rsp_data_reg <= rd_mux;
      out_en_reg    <= pwr_next;
      ramping_reg   <= ramp_next;
      alert_n_reg   <= !(|flag_live);
    end
  end

  assign RSP_VALID = rsp_valid_reg;
  assign RSP_DATA  = rsp_data_reg;
  assign OUTPUT_EN = out_en_reg;
  assign RAMPING   = ramping_reg;
  assign ALERT_N   = alert_n_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  chk_ov_read_only: assert property (
    CE && wr_ov |=> $stable(ov_cfg_reg) && flag_reg[FL_CML])
    else $error("overvoltage response byte accepted a write");
  chk_bad_action: assert property (
    CE && uv_bad |=> flag_reg[FL_CML] && $stable(uv_cfg_reg))
    else $error("action 11 write not refused with CML");
  chk_oc_ramp_quiet: assert property (
    CE && (state_reg == ST_RAMP_ON || state_reg == ST_RAMP_OFF) &&
    !flag_reg[FL_OC] |=> !flag_reg[FL_OC])
    else $error("overcurrent seen during a ramp");
  chk_trip_shutdown: assert property (
    CE && state_reg == ST_ON && trip_any |=> !OUTPUT_EN ##1 !OUTPUT_EN)
    else $error("output not disabled after a trip");
  chk_latch_holds: assert property (
    CE && state_reg == ST_LATCH && run_on && !clr_cmd |=> !OUTPUT_EN)
    else $error("latched output restarted by itself");
  chk_flag_set_wins: assert property (
    CE && ov_evt && clear_all |=> flag_reg[FL_OV])
    else $error("clear beat a new overvoltage event");
  chk_uv_alert: assert property (
    CE && uv_evt && !ALERT_MASK[FL_UV] |=> !ALERT_N)
    else $error("undervoltage did not raise alert");
  chk_retry_wait: assert property (
    CE && state_reg == ST_RETRY && !retry_done |=> !OUTPUT_EN)
    else $error("retry restarted before the interval");
  chk_oc_read_zero: assert property (
    CE && rd && CMD_CODE == CMD_OC_RESP && oc_dly_hide
    |=> RSP_VALID && RSP_DATA[2:0] == 3'h0)
    else $error("overcurrent delay read back nonzero");

  cov_latch: cover property (state_reg == ST_ON ##1 state_reg == ST_LATCH);
  cov_retry: cover property (state_reg == ST_RETRY ##1
                             state_reg == ST_RAMP_ON);
  cov_oc_trip: cover property (oc_tif.trip);
  cov_clear: cover property (flag_reg[FL_OV] && clr_cmd);

endmodule // ofr_fault_resp
`default_nettype wire

/* ofr_host_model.sv */
// Host side of the command port: issues one command per call.
// Assumes the block answers reads with a one-cycle RSP_VALID pulse.
`timescale 1ns/1ps
`default_nettype none
module ofr_host_model (
  input  wire logic        CLK,
  input  wire logic        RSP_VALID,
  input  wire logic [15:0] RSP_DATA,
  output var  logic        CMD_VALID,
  output var  logic        CMD_WRITE,
  output var  logic [7:0]  CMD_CODE,
  output var  logic [15:0] CMD_DATA
);
  initial begin
    CMD_VALID = 1'b0;
    CMD_WRITE = 1'b0;
    CMD_CODE  = 8'h00;
    CMD_DATA  = 16'h0000;
  end
  // Pulse valid for one edge, then wait a bounded time for a read answer
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] rd);
    int k;
    @(negedge CLK);
    CMD_VALID = 1'b1;
    CMD_WRITE = w;
    CMD_CODE  = c;
    CMD_DATA  = d;
    @(negedge CLK);
    CMD_VALID = 1'b0;
    rd = 16'hDEAD;
    for (k = 0; k < 4 && !w && RSP_VALID !== 1'b1; k++) begin
      @(negedge CLK);
    end
    if (!w) begin
      rd = RSP_DATA;
    end
  endtask
endmodule // ofr_host_model
`default_nettype wire

/* output_fault_response_logic_test.sv */
// Self-checking bench for the output fault response engine.
// Assumes short ms and ramp counts; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module output_fault_response_logic_test;
  import ofr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, run = 1'b0, op_on = 1'b0;
  logic ps = 1'b0, uv = 1'b0, oc = 1'b0, ce = 1'b1;
  logic [3:0]  amask = 4'h0;
  logic cv, cw, rv, oen, rmp, alert_n;
  logic [7:0]  cc;
  logic [15:0] cd, rdat, r;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  always #20 clk = ~clk;
  ofr_host_model host (.CLK(clk), .RSP_VALID(rv), .RSP_DATA(rdat),
    .CMD_VALID(cv), .CMD_WRITE(cw), .CMD_CODE(cc), .CMD_DATA(cd));
  ofr_fault_resp #(.MS_CYC(20), .RAMP_CYC(8)) dut (.CLK(clk), .RST(rst),
    .CE(ce), .CMD_VALID(cv), .CMD_WRITE(cw), .CMD_CODE(cc),
    .CMD_DATA(cd), .OPERATION_ON(op_on), .ALERT_MASK(amask),
    .OV_FAULT_IN(1'b0), .PSTAGE_FAULT_IN(ps), .UVLO_FAULT_IN(1'b0),
    .GDS_UV_FAULT_IN(1'b0), .UV_FAULT_IN(uv), .OC_FAULT_IN(oc),
    .RUN_IN(run), .RSP_VALID(rv), .RSP_DATA(rdat), .OUTPUT_EN(oen),
    .RAMPING(rmp), .ALERT_N(alert_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    host.xfer(1'b0, c, 16'h0000, r);
    chk(r, exp);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host.xfer(1'b1, c, d, r);
  endtask
  // Waits a bounded time for a settled output state
  task automatic wait_out(input logic want);
    int k;
    for (k = 0; k < 60 && !(oen === want && rmp === 1'b0); k++) begin
      @(negedge clk);
    end
    chk({15'h0000, oen}, {15'h0000, want});
  endtask
  task automatic conclude();
    $display("Tests %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic t_regs();
    rd(CMD_OV_RESP, 16'h0080);
    rd(CMD_UV_RESP, 16'h00B8);
    rd(CMD_OC_RESP, 16'h0000);
    wr(CMD_OV_RESP, 16'h0000);
    rd(CMD_OV_RESP, 16'h0080);
    rd(CMD_STATUS_BYTE, 16'h0002);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    wr(CMD_UV_RESP, 16'h00C0);
    rd(CMD_UV_RESP, 16'h00B8);
    rd(CMD_STATUS_BYTE, 16'h0002);
    wr(CMD_UV_RESP, 16'h0080);
    rd(CMD_UV_RESP, 16'h0080);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    rd(CMD_STATUS_BYTE, 16'h0000);
  endtask
  task automatic t_ramp();
    run = 1'b1;
    op_on = 1'b1;
    while (oen !== 1'b1 && cyc < 19000) @(negedge clk);
    // A short overcurrent inside the ramp must leave no trace
    oc = 1'b1;
    repeat (3) @(negedge clk);
    oc = 1'b0;
    wait_out(1'b1);
    rd(CMD_STATUS_IOUT, 16'h0000);
  endtask
  task automatic t_uv();
    uv = 1'b1;
    wait_out(1'b0);
    chk({15'h0000, alert_n}, 16'h0000);
    uv = 1'b0;
    repeat (40) @(negedge clk);
    chk({15'h0000, oen}, 16'h0000);
    rd(CMD_STATUS_VOUT, 16'h0010);
    rd(CMD_STATUS_WORD, 16'h8000);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    chk({15'h0000, alert_n}, 16'h0001);
    wait_out(1'b1);
  endtask
  task automatic t_ov();
    amask = 4'h1;
    ps = 1'b1;
    wait_out(1'b0);
    ps = 1'b0;
    chk({15'h0000, alert_n}, 16'h0001);
    amask = 4'h0;
    rd(CMD_STATUS_BYTE, 16'h0020);
    chk({15'h0000, alert_n}, 16'h0000);
    rd(CMD_STATUS_VOUT, 16'h0080);
    wr(CMD_STATUS_VOUT, 16'h0080);
    rd(CMD_STATUS_VOUT, 16'h0000);
  endtask
  // Immediate overcurrent with endless retry at a short 5 ms interval
  task automatic t_oc();
    int k;
    wr(CMD_RETRY_INTVL, 16'h0005);
    rd(CMD_RETRY_INTVL, 16'h0005);
    wr(CMD_OC_RESP, 16'h00FA);
    rd(CMD_OC_RESP, 16'h00F8);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    wait_out(1'b1);
    oc = 1'b1;
    wait_out(1'b0);
    oc = 1'b0;
    chk({15'h0000, alert_n}, 16'h0000);
    rd(CMD_STATUS_BYTE, 16'h0010);
    rd(CMD_STATUS_WORD, 16'h4010);
    repeat (80) @(negedge clk);
    chk({15'h0000, oen}, 16'h0000);
    for (k = 0; k < 200 && oen !== 1'b1; k++) begin
      @(negedge clk);
    end
    chk({15'h0000, oen}, 16'h0001);
  endtask
  // Ignore mode, then a delayed undervoltage with a dropout in between
  task automatic t_dly();
    wr(CMD_UV_RESP, 16'h0000);
    uv = 1'b1;
    repeat (20) @(negedge clk);
    chk({15'h0000, oen}, 16'h0001);
    chk({15'h0000, alert_n}, 16'h0000);
    uv = 1'b0;
    wr(CMD_UV_RESP, 16'h0042);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    uv = 1'b1;
    repeat (300) @(negedge clk);
    chk({15'h0000, oen}, 16'h0001);
    uv = 1'b0;
    repeat (10) @(negedge clk);
    uv = 1'b1;
    repeat (400) @(negedge clk);
    chk({15'h0000, oen}, 16'h0001);
    repeat (400) @(negedge clk);
    chk({15'h0000, oen}, 16'h0000);
    uv = 1'b0;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_regs();
    t_ramp();
    t_uv();
    t_ov();
    t_oc();
    t_dly();
    conclude();
  end
endmodule // output_fault_response_logic_test
`default_nettype wire
